// file: hw/pwm_time_base_defs.svh
`ifndef PWM_TIME_BASE_DEFS_SVH
`define PWM_TIME_BASE_DEFS_SVH

// register offsets (word addresses on the plain register port)
`define OFF_TIME_BASE_CONTROL 4'h0
`define OFF_CLOCK_PRESCALE 4'h1
`define OFF_MASTER_PERIOD 4'h2
`define OFF_SPECIAL_EVENT_CMP 4'h3
`define OFF_CHOP_CLOCK 4'h4
`define OFF_MASTER_COUNTER 4'h5

// time-base control field positions
`define TBC_ENABLE_BIT 15
`define TBC_IDLE_STOP_BIT 13
`define TBC_SE_PENDING_BIT 12
`define TBC_SE_IRQ_EN_BIT 11
`define TBC_IMM_UPDATE_BIT 10
`define TBC_SYNC_POL_BIT 9
`define TBC_SYNC_OEN_BIT 8
`define TBC_EXT_SYNC_EN_BIT 7
`define TBC_SYNC_SRC_HI 6
`define TBC_SYNC_SRC_LO 4
`define TBC_POSTSCALE_HI 3
`define TBC_POSTSCALE_LO 0

// chop register fields
`define CHOP_ENABLE_BIT 15
`define CHOP_DIV_HI 9

// reset values
`define RST_TIME_BASE_CONTROL 16'h0000
`define RST_CLOCK_PRESCALE 3'h0
`define RST_MASTER_PERIOD 16'hFFF8
`define RST_SPECIAL_EVENT_CMP 16'h0000
`define RST_CHOP_DIV 10'h000

// writable masks and reserved select codes
`define MASK_TIME_BASE_CONTROL 16'hAFFF
`define SYNC_SRC_RESERVED 3'h7
`define PRESCALE_RESERVED 3'h7

`endif

// file: hw/pwm_time_base_pkg.sv
package pwm_time_base_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

    typedef struct packed {
        logic enable;
        logic idleStop;
        logic seIrqEnable;
        logic immUpdate;
        logic syncPolInvert;
        logic syncOutEnable;
        logic extSyncEnable;
        logic [2:0] syncSource;
        logic [3:0] postscale;
    } tb_ctrl_s;

endpackage

// file: hw/clock_prescaler.sv
`timescale 1ns/1ps
`include "pwm_time_base_defs.svh"

// emits one tick every 2**sel clocks while running; sel 7 yields no tick
module clock_prescaler (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic run,
    input wire logic [2:0] sel,
    // tick out
    output logic tick
);
    logic [5:0] count_q;
    logic [5:0] limit;

    always_comb begin
        limit = 6'(7'h7F >> (3'h7 - sel)) & 6'h3F;
        if (sel == 3'h0) begin
            limit = 6'h00;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || !run || sel == `PRESCALE_RESERVED) begin
            count_q <= 6'h00;
        end else if (count_q >= limit) begin
            count_q <= 6'h00;
        end else begin
            count_q <= count_q + 6'h01;
        end
    end

    assign tick = run && sel != `PRESCALE_RESERVED && count_q >= limit;
endmodule // clock_prescaler

// file: hw/chop_clock_gen.sv
`timescale 1ns/1ps
`include "pwm_time_base_defs.svh"

// divides prescaled ticks by (div + 1) and toggles the chop clock each wrap
module chop_clock_gen (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // control
    input wire logic enable,
    input wire logic tick,
    input wire logic [9:0] div,
    // chop clock
    output logic chopClk
);
    logic [9:0] count_q;
    logic chop_q;

    always_ff @(posedge clk) begin
        if (!resetn || !enable) begin
            count_q <= 10'h000;
            chop_q <= 1'b0;
        end else if (tick) begin
            if (count_q >= div) begin
                count_q <= 10'h000;
                chop_q <= ~chop_q;
            end else begin
                count_q <= count_q + 10'h001;
            end
        end
    end

    assign chopClk = chop_q;
endmodule // chop_clock_gen

// file: hw/pwm_master_time_base.sv
`timescale 1ns/1ps
`include "pwm_time_base_defs.svh"

module pwm_master_time_base
    import pwm_time_base_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // system
    input wire logic cpuIdle,
    // external sync sources, one per select code 0..6
    input wire logic [6:0] syncSources,
    // outputs
    output logic syncOutPin,
    output logic syncOutEn,
    output logic specialEventTrigger,
    output logic specialEventIrq,
    output logic chopClock,
    output logic cycleStart
);
    reg_req_s req;
    tb_ctrl_s ctrl_q;
    logic sePending_q;
    logic [2:0] prescale_q;
    logic [15:0] periodBuf_q;
    logic [15:0] periodAct_q;
    logic [15:0] compare_q;
    logic chopEn_q;
    logic [9:0] chopDiv_q;
    logic [15:0] counter_q;
    logic [15:0] rdata_q;
    logic syncPrev_q;
    logic syncOut_q;
    logic syncOutEn_q;
    logic trig_q;
    logic irq_q;
    logic chop_q;
    logic cycle_q;
    logic running;
    logic tick;
    logic chopRaw;
    logic syncSel;
    logic syncLevel;
    logic syncEdge;
    logic wrap;
    logic match;
    logic wrCtrl;
    logic wrPeriod;

    assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
    assign wrCtrl = req.wr && req.addr == `OFF_TIME_BASE_CONTROL;
    assign wrPeriod = req.wr && req.addr == `OFF_MASTER_PERIOD;

    // counter advances only when enabled and not stopped by idle
    assign running = ctrl_q.enable && !(ctrl_q.idleStop && cpuIdle);

    clock_prescaler u_prescaler (
        .clk(clk),
        .resetn(resetn),
        .run(running),
        .sel(prescale_q),
        .tick(tick)
    );

    chop_clock_gen u_chop (
        .clk(clk),
        .resetn(resetn),
        .enable(chopEn_q && ctrl_q.enable),
        .tick(tick),
        .div(chopDiv_q),
        .chopClk(chopRaw)
    );

    // sync source mux; reserved code selects nothing
    always_comb begin
        syncSel = 1'b0;
        if (ctrl_q.syncSource != `SYNC_SRC_RESERVED) begin
            syncSel = syncSources[ctrl_q.syncSource];
        end
    end

    assign syncLevel = syncSel ^ ctrl_q.syncPolInvert;
    assign syncEdge = ctrl_q.extSyncEnable && syncLevel && !syncPrev_q;
    assign wrap = tick && counter_q >= periodAct_q;
    assign match = tick && counter_q == compare_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            syncPrev_q <= 1'b0;
        end else begin
            syncPrev_q <= syncLevel;
        end
    end

    // control register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q <= tb_ctrl_s'(14'h0000);
        end else if (wrCtrl) begin
            ctrl_q.enable <= req.wdata[`TBC_ENABLE_BIT];
            ctrl_q.idleStop <= req.wdata[`TBC_IDLE_STOP_BIT];
            ctrl_q.seIrqEnable <= req.wdata[`TBC_SE_IRQ_EN_BIT];
            ctrl_q.immUpdate <= req.wdata[`TBC_IMM_UPDATE_BIT];
            ctrl_q.syncPolInvert <= req.wdata[`TBC_SYNC_POL_BIT];
            ctrl_q.syncOutEnable <= req.wdata[`TBC_SYNC_OEN_BIT];
            ctrl_q.extSyncEnable <= req.wdata[`TBC_EXT_SYNC_EN_BIT];
            ctrl_q.syncSource <=
                req.wdata[`TBC_SYNC_SRC_HI:`TBC_SYNC_SRC_LO];
            ctrl_q.postscale <=
                req.wdata[`TBC_POSTSCALE_HI:`TBC_POSTSCALE_LO];
        end
    end

    // pending flag: hardware only; set on match, cleared when irq disabled
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sePending_q <= 1'b0;
        end else if (match && ctrl_q.enable) begin
            sePending_q <= 1'b1;
        end else if (!ctrl_q.seIrqEnable) begin
            sePending_q <= 1'b0;
        end
    end

    // prescale, compare and chop registers
    always_ff @(posedge clk) begin
        if (!resetn) begin
            prescale_q <= `RST_CLOCK_PRESCALE;
            compare_q <= `RST_SPECIAL_EVENT_CMP;
            chopEn_q <= 1'b0;
            chopDiv_q <= `RST_CHOP_DIV;
        end else if (req.wr) begin
            if (req.addr == `OFF_CLOCK_PRESCALE) begin
                prescale_q <= req.wdata[2:0];
            end
            if (req.addr == `OFF_SPECIAL_EVENT_CMP) begin
                compare_q <= req.wdata;
            end
            if (req.addr == `OFF_CHOP_CLOCK) begin
                chopEn_q <= req.wdata[`CHOP_ENABLE_BIT];
                chopDiv_q <= req.wdata[`CHOP_DIV_HI:0];
            end
        end
    end

    // period buffer and active period
    always_ff @(posedge clk) begin
        if (!resetn) begin
            periodBuf_q <= `RST_MASTER_PERIOD;
            periodAct_q <= `RST_MASTER_PERIOD;
        end else begin
            if (wrPeriod) begin
                periodBuf_q <= req.wdata;
            end
            if (wrPeriod && ctrl_q.immUpdate) begin
                periodAct_q <= req.wdata;
            end else if (wrap || !ctrl_q.enable) begin
                periodAct_q <= periodBuf_q;
            end
        end
    end

    // primary master counter
    always_ff @(posedge clk) begin
        if (!resetn || !ctrl_q.enable) begin
            counter_q <= 16'h0000;
        end else if (syncEdge) begin
            counter_q <= 16'h0000;
        end else if (wrap) begin
            counter_q <= 16'h0000;
        end else if (tick) begin
            counter_q <= counter_q + 16'h0001;
        end
    end

    // event and sync outputs, all registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            trig_q <= 1'b0;
            irq_q <= 1'b0;
            syncOut_q <= 1'b0;
            syncOutEn_q <= 1'b0;
            chop_q <= 1'b0;
            cycle_q <= 1'b0;
        end else begin
            trig_q <= match && ctrl_q.enable;
            irq_q <= sePending_q && ctrl_q.seIrqEnable;
            // one-cycle sync pulse at each period start
            syncOut_q <= ((wrap || syncEdge) && ctrl_q.enable)
                ^ ctrl_q.syncPolInvert;
            syncOutEn_q <= ctrl_q.syncOutEnable;
            chop_q <= chopRaw;
            cycle_q <= (wrap || syncEdge) && ctrl_q.enable;
        end
    end

    // read data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= 16'h0000;
        end else if (req.rd) begin
            unique case (req.addr)
                `OFF_TIME_BASE_CONTROL: begin
                    rdata_q <= {ctrl_q.enable, 1'b0, ctrl_q.idleStop,
                        sePending_q, ctrl_q.seIrqEnable, ctrl_q.immUpdate,
                        ctrl_q.syncPolInvert, ctrl_q.syncOutEnable,
                        ctrl_q.extSyncEnable, ctrl_q.syncSource,
                        ctrl_q.postscale};
                end
                `OFF_CLOCK_PRESCALE: begin
                    rdata_q <= {13'h0000, prescale_q};
                end
                `OFF_MASTER_PERIOD: begin
                    rdata_q <= periodBuf_q;
                end
                `OFF_SPECIAL_EVENT_CMP: begin
                    rdata_q <= compare_q;
                end
                `OFF_CHOP_CLOCK: begin
                    rdata_q <= {chopEn_q, 5'h00, chopDiv_q};
                end
                `OFF_MASTER_COUNTER: begin
                    rdata_q <= counter_q;
                end
                default: begin
                    rdata_q <= 16'h0000;
                end
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign regRdata = rdata_q;
    assign syncOutPin = syncOut_q;
    assign syncOutEn = syncOutEn_q;
    assign specialEventTrigger = trig_q;
    assign specialEventIrq = irq_q;
    assign chopClock = chop_q;
    assign cycleStart = cycle_q;
endmodule // pwm_master_time_base

// file: test/time_base_checker.sv
`timescale 1ns/1ps

module time_base_checker (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [15:0] regRdata,
    // pins
    input wire logic cpuIdle,
    input wire logic syncOutPin,
    input wire logic syncOutEn,
    input wire logic specialEventTrigger,
    input wire logic specialEventIrq,
    input wire logic chopClock,
    input wire logic cycleStart
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    logic enQ, idleQ, polQ, chopQ;
    wire ctlWr = regWr && regAddr == 4'h0;
    // shadow of the control bits as software wrote them
    always_ff @(posedge clk) begin
        if (!resetn) begin
            enQ <= 1'b0;
            idleQ <= 1'b0;
            polQ <= 1'b0;
        end else if (ctlWr) begin
            enQ <= regWdata[15];
            idleQ <= regWdata[13];
            polQ <= regWdata[9];
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            chopQ <= 1'b0;
        end else if (regWr && regAddr == 4'h4) begin
            chopQ <= regWdata[15];
        end
    end
    sequence sOff;
        !enQ [*3];
    endsequence
    sequence sHalt;
        (idleQ && cpuIdle) [*3];
    endsequence
    sequence sChopOff;
        !chopQ [*3];
    endsequence
    AST_RD_SLOT: assert property (!regRd |=> regRdata == 16'h0000)
        else $error("read data outside its slot");
    AST_UNMAPPED: assert property (regRd && regAddr > 4'h5 |=>
        regRdata == 16'h0000) else $error("unmapped read not zero");
    AST_TRIG_ONE: assert property (specialEventTrigger |=>
        !specialEventTrigger) else $error("trigger longer than a cycle");
    AST_IRQ_CAUSE: assert property ($rose(specialEventIrq) |->
        $past(specialEventTrigger)) else $error("irq without event");
    AST_OEN: assert property (ctlWr ##1 !ctlWr |=>
        syncOutEn == $past(regWdata[8], 2)) else $error("pad enable wrong");
    AST_POL: assert property (cycleStart |-> syncOutPin != polQ)
        else $error("sync pulse polarity wrong");
    AST_OFF: assert property (sOff |->
        !cycleStart && !specialEventTrigger) else $error("runs while off");
    AST_IDLE: assert property (sHalt |-> !cycleStart)
        else $error("counts during idle");
    AST_CHOP: assert property (sChopOff |=> $stable(chopClock))
        else $error("chop runs while off");
endmodule // time_base_checker

bind pwm_master_time_base time_base_checker time_base_checker_inst (
    .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuIdle(cpuIdle),
    .syncOutPin(syncOutPin), .syncOutEn(syncOutEn),
    .specialEventTrigger(specialEventTrigger),
    .specialEventIrq(specialEventIrq), .chopClock(chopClock),
    .cycleStart(cycleStart));

// file: test/sync_partner.sv
`timescale 1ns/1ps

// drives one sync source on request and counts sync output pulses
module sync_partner (
    // clock
    input wire logic clk,
    // stimulus control
    input wire logic fire,
    input wire logic [2:0] src,
    input wire logic pol,
    // pins
    output logic [6:0] syncSources,
    input wire logic syncOutPin,
    input wire logic syncOutEn,
    // observation
    output int seen
);
    logic [1:0] leftQ = 2'h0;
    logic prevQ = 1'b0;
    wire [6:0] act = (leftQ != 2'h0) ? (7'h01 << src) : 7'h00;
    initial seen = 0;
    always @(posedge clk) begin
        if (fire) begin
            leftQ <= 2'h3;
        end else if (leftQ != 2'h0) begin
            leftQ <= leftQ - 2'h1;
        end
    end
    assign syncSources = {7{pol}} ^ act;
    always @(posedge clk) begin
        prevQ <= syncOutPin ^ pol;
        if (syncOutEn && (syncOutPin ^ pol) && !prevQ) begin
            seen <= seen + 1;
        end
    end
endmodule // sync_partner

// file: test/tb_pwm_master_time_base.sv
`timescale 1ns/1ps
`include "pwm_time_base_defs.svh"

module tb_pwm_master_time_base;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic cpuIdle = 1'b0;
    logic fire = 1'b0;
    logic [2:0] src = 3'h0;
    logic pol = 1'b0;
    logic [15:0] regRdata;
    logic [6:0] syncSources;
    logic syncOutPin, syncOutEn, specialEventTrigger, specialEventIrq;
    logic chopClock, cycleStart, chopPrev;
    int seen, n, k;
    int n_mismatch = 0;
    int tests_run = 0;
    wire [2:0] ev = {chopClock ^ chopPrev, specialEventTrigger, cycleStart};

    always #25 clk = ~clk;
    always @(posedge clk) chopPrev <= chopClock;

    pwm_master_time_base pwm_master_time_base_inst (
        .clk(clk), .resetn(resetn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .cpuIdle(cpuIdle), .syncSources(syncSources),
        .syncOutPin(syncOutPin), .syncOutEn(syncOutEn),
        .specialEventTrigger(specialEventTrigger),
        .specialEventIrq(specialEventIrq), .chopClock(chopClock),
        .cycleStart(cycleStart));
    sync_partner sync_partner_inst (
        .clk(clk), .fire(fire), .src(src), .pol(pol),
        .syncSources(syncSources), .syncOutPin(syncOutPin),
        .syncOutEn(syncOutEn), .seen(seen));

    task summarize;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, exp);
    endtask
    // counts clocks until event w shows, at most b
    task cnt(input int w, input int b, input bit must, output int c);
        c = 0;
        while (c < b) begin
            @(posedge clk);
            #1;
            c++;
            if (ev[w] === 1'b1) return;
        end
        if (must) begin
            $display("[FAIL] %0t wait ran out", $time);
            n_mismatch++;
            summarize();
        end
    endtask
    task cfg(input logic [15:0] ctl, input logic [15:0] per,
             input logic [2:0] pre);
        wr(`OFF_TIME_BASE_CONTROL, 16'h0000);
        wr(`OFF_CLOCK_PRESCALE, {13'h0000, pre});
        wr(`OFF_MASTER_PERIOD, per);
        wr(`OFF_TIME_BASE_CONTROL, ctl);
    endtask

    task t_regs;
        rd(4'h0, 16'h0000);
        rd(4'h1, 16'h0000);
        rd(4'h2, 16'hFFF8);
        rd(4'h3, 16'h0000);
        rd(4'h4, 16'h0000);
        rd(4'h6, 16'h0000);
        wr(4'h0, 16'h5000);
        rd(4'h0, 16'h0000);
        wr(4'h1, 16'hFFFE);
        rd(4'h1, 16'h0006);
        wr(4'h4, 16'h7FFF);
        rd(4'h4, 16'h03FF);
        wr(4'h3, 16'hA5C3);
        rd(4'h3, 16'hA5C3);
        $display("t_regs done");
    endtask
    task t_event;
        for (int ie = 0; ie < 2; ie++) begin
            wr(4'h3, 16'h0003);
            cfg(ie ? 16'h8800 : 16'h8000, 16'h0007, 3'h0);
            cnt(0, 2000, 1, n);
            cnt(0, 2000, 1, n);
            chk(16'(n), 16'h0008);
            cnt(1, 2000, 1, n);
            @(posedge clk);
            #1;
            chk(16'(specialEventIrq), 16'(ie));
            rd(4'h0, ie ? 16'h9800 : 16'h8000);
        end
        $display("t_event done");
    endtask
    task t_prescale;
        for (int s = 0; s < 7; s++) begin
            cfg(16'h8000, 16'h0003, 3'(s));
            cnt(0, 2000, 1, n);
            cnt(0, 2000, 1, n);
            chk(16'(n), 16'(4 << s));
        end
        $display("t_prescale done");
    endtask
    task t_update;
        for (int im = 0; im < 2; im++) begin
            cfg(im ? 16'h8400 : 16'h8000, 16'h000F, 3'h0);
            cnt(0, 2000, 1, n);
            wr(4'h2, 16'h0006);
            cnt(0, 2000, 1, n);
            chk(16'(n), im ? 16'h0005 : 16'h000E);
        end
        $display("t_update done");
    endtask
    task t_sync;
        for (int s = 0; s < 7; s++) begin
            pol <= s[0];
            src <= 3'(s);
            cfg(16'h8180 | 16'(s << 4) | (s[0] ? 16'h0200 : 16'h0000),
                16'h00C8, 3'h0);
            repeat (5) @(posedge clk);
            k = seen;
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            cnt(0, 8, 0, n);
            chk(16'(n < 8), 16'h0001);
            repeat (3) @(posedge clk);
            chk(16'(seen > k), 16'h0001);
        end
        pol <= 1'b0;
        src <= 3'h0;
        cfg(16'h8100, 16'h00C8, 3'h0);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        cnt(0, 20, 0, n);
        chk(16'(n), 16'h0014);
        $display("t_sync done");
    endtask
    task t_idle;
        cfg(16'hA000, 16'h0007, 3'h0);
        cpuIdle <= 1'b1;
        cnt(0, 40, 0, n);
        chk(16'(n), 16'h0028);
        cpuIdle <= 1'b0;
        cnt(0, 20, 0, n);
        chk(16'(n < 20), 16'h0001);
        cfg(16'h8000, 16'h0007, 3'h0);
        cpuIdle <= 1'b1;
        cnt(0, 2000, 1, n);
        cnt(0, 2000, 1, n);
        chk(16'(n), 16'h0008);
        cpuIdle <= 1'b0;
        $display("t_idle done");
    endtask
    task t_chop;
        for (int i = 0; i < 2; i++) begin
            cfg(16'h8000, 16'h0007, 3'(i));
            wr(4'h4, 16'h8000 | 16'(1 + 3 * i));
            cnt(2, 200, 1, n);
            cnt(2, 200, 1, n);
            chk(16'(n), 16'((2 + 3 * i) << i));
        end
        wr(4'h4, 16'h0001);
        // let the stopping chop clock settle before watching it
        repeat (3) @(posedge clk);
        cnt(2, 20, 0, n);
        cnt(2, 20, 0, n);
        chk(16'(n), 16'h0014);
        $display("t_chop done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_event();
        t_prescale();
        t_update();
        t_sync();
        t_idle();
        t_chop();
        summarize();
    end
endmodule // tb_pwm_master_time_base
